// file: rtl/fp_acc_regs.svh
// Overview of operation
// - exponent path: eight bits, sign, overflow
// - sixty-bit fraction path meets accumulator storage
// - accumulator reads never alter contents
// - slots zero to five open to programs
// - slot six internal only, never program-selected
// - slot seven holds last exception code, address
// - slot seven also holds address, status, code
// - single uses left 32 bits, double 64
// - access whole word or one quadrant
// - quadrant three top, quadrant zero bottom
// - memory integers become sign-magnitude on load
// - memory floats keep sign, exponent; fraction widened
// - results leave as integers or floats
// - only normalized floats go to memory
// - memory float: sign, exponent, 23/55 fraction
// - load inserts hidden one: 24/56 bits
// - internal fraction: bit59 clear, bit58 set
// - store drops internal fraction bits 59,58
// - excess-128 exponent: multiply subtracts, divide adds
`ifndef FP_ACC_REGS_SVH
`define FP_ACC_REGS_SVH

// slot map
`define FPA_LAST_PROG_SLOT 3'h5
`define FPA_SLOT_SCRATCH   3'h6
`define FPA_SLOT_STATUS    3'h7
// status slot quadrants
`define FPA_Q_STATUS       3
`define FPA_Q_CUR_ADDR     2
`define FPA_Q_EXC_ADDR     1
`define FPA_Q_EXC_CODE     0
// reset values
`define FPA_ACC_RESET      64'h0
`define FPA_OP_RESET       64'h0
// memory word fields
`define FPA_SIGN_BIT       63
`define FPA_EXP_HI         62
`define FPA_EXP_LO         55
`define FPA_FRAC_HI        54
`define FPA_SGL_FRAC_LO    32
// internal fraction layout
`define FPA_LEAD_BITS      2'h1
`define FPA_EXP_ZERO       8'h00
// excess-200 octal bias
`define FPA_EXP_BIAS       11'h080

`endif

// file: rtl/fp_acc_pkg.sv
package fp_acc_pkg;
	typedef enum logic [1:0] {kind_int16, kind_int32, kind_single, kind_double} operand_kind_t;
	typedef enum logic {exp_mul, exp_div} exp_op_t;
endpackage

// file: rtl/fp_load_format.sv
`timescale 1ns/1ps
`include "fp_acc_regs.svh"
module fp_load_format (
	input  wire logic [63:0]                word,
	input  wire fp_acc_pkg::operand_kind_t  kind,
	output logic                            sign,
	output logic [7:0]                      exponent,
	output logic [59:0]                     fraction,
	output logic [31:0]                     magnitude
);
	import fp_acc_pkg::*;
	logic [31:0] int_raw;

	// operand to internal sign-magnitude form
	always_comb
	begin
		int_raw = (kind == kind_int16) ? {{16{word[63]}}, word[63:48]} : word[63:32];
		sign = word[`FPA_SIGN_BIT];
		exponent = `FPA_EXP_ZERO;
		fraction = 60'h0;
		magnitude = 32'h0;
		case (kind)
			kind_int16, kind_int32:
			begin
				magnitude = int_raw[31] ? 32'(~int_raw + 32'h1) : int_raw;
			end
			kind_single:
			begin
				exponent = word[`FPA_EXP_HI:`FPA_EXP_LO];
				if (exponent != `FPA_EXP_ZERO)
					fraction = {`FPA_LEAD_BITS, word[`FPA_FRAC_HI:`FPA_SGL_FRAC_LO], 35'h0};
			end
			default:
			begin
				exponent = word[`FPA_EXP_HI:`FPA_EXP_LO];
				if (exponent != `FPA_EXP_ZERO)
					fraction = {`FPA_LEAD_BITS, word[`FPA_FRAC_HI:0], 3'h0};
			end
		endcase
	end
endmodule

// file: rtl/fp_store_format.sv
`timescale 1ns/1ps
`include "fp_acc_regs.svh"
module fp_store_format (
	input  wire logic                       sign,
	input  wire logic [9:0]                 exponent,
	input  wire logic [59:0]                fraction,
	input  wire logic [31:0]                magnitude,
	input  wire fp_acc_pkg::operand_kind_t  kind,
	output logic [63:0]                     word,
	output logic                            unnormal
);
	import fp_acc_pkg::*;
	logic [31:0] int_out;

	// internal form back to memory layout
	always_comb
	begin
		int_out = sign ? 32'(~magnitude + 32'h1) : magnitude;
		unnormal = 1'b0;
		case (kind)
			kind_int16: word = {int_out[15:0], 48'h0};
			kind_int32: word = {int_out, 32'h0};
			kind_single: word = {sign, exponent[7:0], fraction[57:35], 32'h0};
			default: word = {sign, exponent[7:0], fraction[57:3]};
		endcase
		// floats must carry lead bits 01 unless zero
		if ((kind == kind_single || kind == kind_double) && fraction != 60'h0
			&& fraction[59:58] != `FPA_LEAD_BITS)
			unnormal = 1'b1;
	end
endmodule

// file: rtl/fp_acc_file.sv
`timescale 1ns/1ps
`include "fp_acc_regs.svh"
module fp_acc_file #(
	parameter int SLOTS = 8
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       prog_rd,
	input  wire logic                       prog_wr,
	input  wire logic [2:0]                 prog_slot,
	input  wire logic                       prog_quad_mode,
	input  wire logic [1:0]                 prog_quad,
	input  wire logic [63:0]                prog_wdata,
	output logic [63:0]                     prog_rdata,
	output logic                            prog_slot_err,
	input  wire logic                       int_rd,
	input  wire logic                       int_wr,
	input  wire logic [2:0]                 int_slot,
	input  wire logic                       int_quad_mode,
	input  wire logic [1:0]                 int_quad,
	input  wire logic [63:0]                int_wdata,
	output logic [63:0]                     int_rdata,
	input  wire logic                       exc_capture,
	input  wire logic [15:0]                exc_code,
	input  wire logic [15:0]                exc_addr,
	input  wire logic                       stat_save,
	input  wire logic [15:0]                stat_addr,
	input  wire logic [15:0]                stat_word,
	input  wire logic [15:0]                stat_code,
	output logic [15:0]                     exception_cause_code,
	output logic [15:0]                     exception_instruction_address,
	output logic [15:0]                     floating_status_word,
	input  wire logic                       ld_valid,
	input  wire logic                       ld_from_acc,
	input  wire fp_acc_pkg::operand_kind_t  ld_kind,
	input  wire logic [63:0]                mem_rdata,
	output logic                            op_sign,
	output logic [9:0]                      op_exponent,
	output logic [59:0]                     op_fraction,
	output logic [31:0]                     op_magnitude,
	input  wire logic                       exp_valid,
	input  wire fp_acc_pkg::exp_op_t        exp_op,
	input  wire logic [7:0]                 exp_operand,
	input  wire logic                       st_valid,
	input  wire fp_acc_pkg::operand_kind_t  st_kind,
	input  wire logic                       st_to_acc,
	output logic [63:0]                     mem_wdata,
	output logic                            st_done,
	output logic                            st_refused
);
	import fp_acc_pkg::*;

	logic [63:0]  acc [SLOTS];
	logic         prog_legal;
	logic         prog_use;
	logic [63:0]  sel_word;
	logic         wr_en;
	logic [2:0]   wr_slot;
	logic [3:0]   wr_mask;
	logic [63:0]  wr_data;
	logic [63:0]  ld_word;
	logic         ld_sign;
	logic [7:0]   ld_exp;
	logic [59:0]  ld_frac;
	logic [31:0]  ld_mag;
	logic         ld_ok;
	logic [63:0]  st_word;
	logic         st_unnormal;
	logic         st_ok;
	logic [10:0]  exp_sum;
	logic [9:0]   next_exponent;

	// program port may only reach slots 0..5
	assign prog_legal = (prog_slot <= `FPA_LAST_PROG_SLOT);
	assign prog_use = prog_rd | prog_wr | (ld_valid & ld_from_acc) | (st_valid & st_to_acc);
	assign sel_word = acc[prog_slot];

	// slot seven fields straight from storage
	assign exception_cause_code = acc[`FPA_SLOT_STATUS][`FPA_Q_EXC_CODE*16 +: 16];
	assign exception_instruction_address = acc[`FPA_SLOT_STATUS][`FPA_Q_EXC_ADDR*16 +: 16];
	assign floating_status_word = acc[`FPA_SLOT_STATUS][`FPA_Q_STATUS*16 +: 16];

	// operand conversion on load
	assign ld_word = ld_from_acc ? sel_word : mem_rdata;
	assign ld_ok = ld_valid & (~ld_from_acc | prog_legal);

	fp_load_format u_load (
		.word      (ld_word),
		.kind      (ld_kind),
		.sign      (ld_sign),
		.exponent  (ld_exp),
		.fraction  (ld_frac),
		.magnitude (ld_mag)
	);

	// result reassembly for store
	fp_store_format u_store (
		.sign      (op_sign),
		.exponent  (op_exponent),
		.fraction  (op_fraction),
		.magnitude (op_magnitude),
		.kind      (st_kind),
		.word      (st_word),
		.unnormal  (st_unnormal)
	);

	assign st_ok = st_valid & ~st_unnormal & (~st_to_acc | prog_legal);

	// single write port: internal, store, program
	always_comb
	begin
		wr_en = 1'b0;
		wr_slot = int_slot;
		wr_mask = 4'h0;
		wr_data = int_wdata;
		if (int_wr)
		begin
			wr_en = 1'b1;
			wr_mask = int_quad_mode ? 4'(4'h1 << int_quad) : 4'hf;
			wr_data = int_quad_mode ? {4{int_wdata[15:0]}} : int_wdata;
		end
		else if (st_ok && st_to_acc)
		begin
			wr_en = 1'b1;
			wr_slot = prog_slot;
			wr_mask = 4'hf;
			wr_data = st_word;
		end
		else if (prog_wr && prog_legal)
		begin
			wr_en = 1'b1;
			wr_slot = prog_slot;
			wr_mask = prog_quad_mode ? 4'(4'h1 << prog_quad) : 4'hf;
			wr_data = prog_quad_mode ? {4{prog_wdata[15:0]}} : prog_wdata;
		end
	end

	// accumulator storage; status fields land last
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < SLOTS; s++)
				acc[s] <= `FPA_ACC_RESET;
		end
		else
		begin
			if (wr_en)
			begin
				for (int q = 0; q < 4; q++)
					if (wr_mask[q])
						acc[wr_slot][q*16 +: 16] <= wr_data[q*16 +: 16];
			end
			if (stat_save)
			begin
				acc[`FPA_SLOT_STATUS][`FPA_Q_STATUS*16 +: 16] <= stat_word;
				acc[`FPA_SLOT_STATUS][`FPA_Q_CUR_ADDR*16 +: 16] <= stat_addr;
				acc[`FPA_SLOT_STATUS][`FPA_Q_EXC_CODE*16 +: 16] <= stat_code;
			end
			if (exc_capture)
			begin
				acc[`FPA_SLOT_STATUS][`FPA_Q_EXC_ADDR*16 +: 16] <= exc_addr;
				acc[`FPA_SLOT_STATUS][`FPA_Q_EXC_CODE*16 +: 16] <= exc_code;
			end
		end
	end

	// program read, registered, no side effect
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prog_rdata <= `FPA_ACC_RESET;
		else if (prog_rd)
		begin
			if (!prog_legal)
				prog_rdata <= 64'h0;
			else if (prog_quad_mode)
				prog_rdata <= {48'h0, sel_word[{prog_quad, 4'h0} +: 16]};
			else
				prog_rdata <= sel_word;
		end
	end

	// illegal program slot flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prog_slot_err <= 1'b0;
		else
			prog_slot_err <= prog_use & ~prog_legal;
	end

	// internal read reaches every slot
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_rdata <= `FPA_ACC_RESET;
		else if (int_rd)
		begin
			if (int_quad_mode)
				int_rdata <= {48'h0, acc[int_slot][{int_quad, 4'h0} +: 16]};
			else
				int_rdata <= acc[int_slot];
		end
	end

	// operand sign, fraction, magnitude
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_sign <= 1'b0;
			op_fraction <= 60'h0;
			op_magnitude <= 32'h0;
		end
		else if (ld_ok)
		begin
			op_sign <= ld_sign;
			op_fraction <= ld_frac;
			op_magnitude <= ld_mag;
		end
	end

	// biased exponent arithmetic
	always_comb
	begin
		if (exp_op == exp_mul)
			exp_sum = {3'h0, op_exponent[7:0]} + {3'h0, exp_operand} - `FPA_EXP_BIAS;
		else
			exp_sum = {3'h0, op_exponent[7:0]} - {3'h0, exp_operand} + `FPA_EXP_BIAS;
		// overflow, sign of result, eight exponent bits
		next_exponent = {~exp_sum[10] & (exp_sum[9:8] != 2'h0), exp_sum[10], exp_sum[7:0]};
	end

	// exponent register; a load takes precedence
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			op_exponent <= 10'h0;
		else if (ld_ok)
			op_exponent <= {2'h0, ld_exp};
		else if (exp_valid)
			op_exponent <= next_exponent;
	end

	// store result and completion pulses
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mem_wdata <= `FPA_OP_RESET;
			st_done <= 1'b0;
			st_refused <= 1'b0;
		end
		else
		begin
			st_done <= st_ok;
			st_refused <= st_valid & ~st_ok;
			if (st_ok && !st_to_acc)
				mem_wdata <= st_word;
		end
	end

	// helper views for the checks below
	logic [15:0] sel_top;
	logic [47:0] scratch_hi;
	logic [15:0] scratch_lo;
	logic [15:0] int_lane;
	logic [54:0] mem_frac;
	logic [31:0] mem_top32;
	logic [7:0]  exp_low;
	logic [54:0] frac_body;
	logic [7:0]  mem_exp;
	logic [22:0] sgl_body;
	assign sel_top = sel_word[63:48];
	assign scratch_hi = acc[`FPA_SLOT_SCRATCH][63:16];
	assign scratch_lo = acc[`FPA_SLOT_SCRATCH][15:0];
	assign int_lane = int_wdata[15:0];
	assign mem_frac = mem_rdata[54:0];
	assign mem_top32 = mem_rdata[63:32];
	assign exp_low = op_exponent[7:0];
	assign frac_body = op_fraction[57:3];
	assign mem_exp = mem_rdata[62:55];
	assign sgl_body = op_fraction[57:35];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// slot guards on the program side
	a_prog_slot_guard: assert property (prog_wr && !prog_legal |=> prog_slot_err && $stable(scratch_hi))
		else $error("program reached a reserved slot");
	a_store_slot_guard: assert property (st_valid && st_to_acc && !prog_legal
		|=> st_refused && prog_slot_err && !st_done)
		else $error("store reached a reserved slot");
	a_illegal_read_zero: assert property (prog_rd && !prog_legal |=> prog_rdata == 64'h0)
		else $error("reserved slot read returned data");
	a_slot_err_quiet: assert property (!prog_use |=> !prog_slot_err)
		else $error("slot error without program access");

	// storage, quadrant and slot seven checks
	a_read_keeps_data: assert property (prog_rd && !wr_en && !stat_save && !exc_capture
		##1 $stable(prog_slot) |-> $stable(sel_word))
		else $error("read disturbed accumulator");
	a_quad_top_read: assert property (prog_rd && prog_legal && prog_quad_mode && prog_quad == 2'h3
		|=> prog_rdata == {48'h0, $past(sel_top)})
		else $error("quadrant three is not the top lane");
	a_quad_write_only: assert property (int_wr && int_quad_mode && int_quad == 2'h0 && int_slot == 3'h6
		|=> $stable(scratch_hi) && scratch_lo == $past(int_lane))
		else $error("quadrant write touched other lanes");
	a_exc_capture: assert property (exc_capture |=> exception_cause_code == $past(exc_code)
		&& exception_instruction_address == $past(exc_addr))
		else $error("exception fields not captured");
	a_stat_save: assert property (stat_save && !exc_capture |=> floating_status_word == $past(stat_word)
		&& exception_cause_code == $past(stat_code))
		else $error("status save lost");

	// load path checks
	a_load_hidden: assert property (ld_valid && !ld_from_acc && ld_kind == kind_double
		&& mem_exp != 8'h0 |=> op_fraction[59:58] == 2'h1 && frac_body == $past(mem_frac))
		else $error("hidden bit not inserted");
	a_load_single: assert property (ld_valid && !ld_from_acc && ld_kind == kind_single && mem_exp != 8'h0
		|=> op_fraction[59:58] == 2'h1 && op_fraction[34:0] == 35'h0)
		else $error("single fraction not widened");
	a_float_exp_pass: assert property (ld_valid && !ld_from_acc && ld_kind == kind_single
		|=> op_exponent == {2'h0, $past(mem_exp)})
		else $error("float exponent altered on load");
	a_int_magnitude: assert property (ld_valid && !ld_from_acc && ld_kind == kind_int32
		|=> (op_sign ? 32'(~op_magnitude + 32'h1) : op_magnitude) == $past(mem_top32))
		else $error("integer not converted to sign-magnitude");
	a_int_no_frac: assert property (ld_ok && (ld_kind == kind_int16 || ld_kind == kind_int32)
		|=> op_fraction == 60'h0 && op_exponent == 10'h0)
		else $error("integer load left float fields");

	// exponent checks
	a_exp_bias_mul: assert property (exp_valid && exp_op == exp_mul && !ld_ok
		|=> 8'(exp_low + 8'h80) == 8'($past(exp_low) + $past(exp_operand)))
		else $error("multiply bias wrong");
	a_exp_bias_div: assert property (exp_valid && exp_op == exp_div && !ld_ok
		|=> 8'(exp_low + 8'h80) == 8'($past(exp_low) - $past(exp_operand)))
		else $error("divide bias wrong");

	// store path checks
	a_store_drops_lead: assert property (st_valid && !st_unnormal && !st_to_acc && st_kind == kind_double
		|=> mem_wdata[54:0] == $past(frac_body) && st_done)
		else $error("store kept lead bits");
	a_store_single: assert property (st_valid && !st_unnormal && !st_to_acc && st_kind == kind_single
		|=> mem_wdata[54:32] == $past(sgl_body) && mem_wdata[31:0] == 32'h0)
		else $error("single store misplaced");
	a_store_int32: assert property (st_valid && !st_to_acc && st_kind == kind_int32
		|=> mem_wdata[63:32] == ($past(op_sign) ? 32'(~$past(op_magnitude) + 32'h1) : $past(op_magnitude)))
		else $error("integer store not two's complement");
	a_unnormal_refused: assert property (st_valid && st_unnormal |=> st_refused && !st_done)
		else $error("unnormalized float stored");

	c_exc_capture: cover property (exc_capture ##1 stat_save);
	c_quad_round: cover property (prog_wr && prog_quad_mode ##1 prog_rd && prog_quad_mode);
	c_store_mem: cover property (ld_valid && ld_kind == kind_single ##1 st_valid && !st_to_acc);
	c_div_exp: cover property (exp_valid && exp_op == exp_div);
	c_scratch_quad: cover property (int_wr && int_quad_mode && int_slot == 3'h6);
endmodule

// file: testbench/host_mem.sv
`timescale 1ns/1ps
// host side: hands over load words, keeps each accepted store word
module host_mem (
	input  wire logic        clk,
	input  wire logic        ld_valid,
	input  wire logic [63:0] word,
	input  wire logic        st_done,
	input  wire logic [63:0] mem_wdata,
	output logic      [63:0] mem_rdata,
	output logic      [63:0] stored
);
	// bus shows the word only with the load strobe, inverse otherwise
	assign mem_rdata = ld_valid ? word : ~word;
	// capture the stored word on acceptance
	always_ff @(posedge clk)
	begin
		if (st_done)
			stored <= mem_wdata;
	end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import fp_acc_pkg::*;
	localparam logic [8:0] P_RD = 9'h100, P_WR = 9'h080, I_RD = 9'h040, I_WR = 9'h020, EXC = 9'h010;
	localparam logic [8:0] STAT = 9'h008, LD = 9'h004, EXP = 9'h002, ST = 9'h001;
	logic          clk = 1'b0, rst, prog_rd, prog_wr, prog_quad_mode, int_rd, int_wr, int_quad_mode, qm;
	logic          exc_capture, stat_save, ld_valid, ld_from_acc, exp_valid, st_valid, st_to_acc;
	logic          prog_slot_err, op_sign, st_done, st_refused;
	logic [1:0]    prog_quad, int_quad, q;
	logic [2:0]    prog_slot, int_slot, s;
	logic [7:0]    exp_operand;
	logic [9:0]    op_exponent;
	logic [15:0]   exc_code, exc_addr, stat_addr, stat_word, stat_code;
	logic [15:0]   exception_cause_code, exception_instruction_address, floating_status_word;
	logic [31:0]   op_magnitude, v;
	logic [59:0]   op_fraction;
	logic [63:0]   prog_wdata, prog_rdata, int_wdata, int_rdata, mem_rdata, mem_wdata, word, stored, d;
	logic [63:0]   acc [0:5];
	operand_kind_t ld_kind, st_kind, k;
	exp_op_t       exp_op;
	int            fail_count, compares, t;

	fp_acc_file uut (.clk, .rst, .prog_rd, .prog_wr, .prog_slot, .prog_quad_mode, .prog_quad, .prog_wdata,
		.prog_rdata, .prog_slot_err, .int_rd, .int_wr, .int_slot, .int_quad_mode, .int_quad, .int_wdata,
		.int_rdata, .exc_capture, .exc_code, .exc_addr, .stat_save, .stat_addr, .stat_word, .stat_code,
		.exception_cause_code, .exception_instruction_address, .floating_status_word, .ld_valid,
		.ld_from_acc, .ld_kind, .mem_rdata, .op_sign, .op_exponent, .op_fraction, .op_magnitude, .exp_valid,
		.exp_op, .exp_operand, .st_valid, .st_kind, .st_to_acc, .mem_wdata, .st_done, .st_refused);
	host_mem hm (.clk, .ld_valid, .word, .st_done, .mem_wdata, .mem_rdata, .stored);

	// clock, 5 ns period
	always #2.5 clk = ~clk;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// set every strobe at once, then one cycle
	task automatic go(input logic [8:0] m);
		{prog_rd, prog_wr, int_rd, int_wr, exc_capture, stat_save, ld_valid, exp_valid, st_valid} = m;
		@(negedge clk);
	endtask

	task automatic pacc(input logic w, input logic [2:0] sl, input logic m, input logic [1:0] qq, input logic [63:0] dd);
		prog_slot = sl;
		prog_quad_mode = m;
		prog_quad = qq;
		prog_wdata = dd;
		go(w ? P_WR : P_RD);
	endtask

	task automatic iacc(input logic w, input logic [2:0] sl, input logic m, input logic [1:0] qq, input logic [63:0] dd);
		int_slot = sl;
		int_quad_mode = m;
		int_quad = qq;
		int_wdata = dd;
		go(w ? I_WR : I_RD);
	endtask

	function automatic logic [63:0] quad(input logic [63:0] x, input logic [1:0] qq);
		return (x >> {qq, 4'h0}) & 64'hffff;
	endfunction

	// memory form of a word after a load and store round trip
	function automatic logic [63:0] mform(input operand_kind_t kk, input logic [63:0] x);
		if (kk == kind_int16)
			return {x[63:48], 48'h0};
		if (kk == kind_double)
			return x;
		return {x[63:32], 32'h0};
	endfunction

	// watchdog, far beyond the expected run
	initial
	begin
		#100000;
		fail_count++;
		end_sim();
	end

	initial
	begin
		{prog_quad_mode, int_quad_mode, ld_from_acc, st_to_acc, exp_operand} = '0;
		{prog_quad, int_quad, prog_slot, int_slot, prog_wdata, int_wdata, word} = '0;
		{exc_code, exc_addr, stat_addr, stat_word, stat_code} = '0;
		ld_kind = kind_int16;
		st_kind = kind_int16;
		exp_op = exp_mul;
		{fail_count, compares} = '0;
		rst = 1;
		go(9'h0);
		repeat (2) @(negedge clk);
		rst = 0;
		void'($urandom(32'hd60def83));
		chk(prog_rdata | mem_wdata | op_fraction, 64'h0);
		// fill the program slots, then random whole and quadrant traffic
		for (int i = 0; i < 6; i++)
		begin
			acc[i] = {$urandom, $urandom};
			pacc(1, 3'(i), 0, 0, acc[i]);
		end
		repeat (80)
		begin
			s = 3'($urandom_range(5));
			q = 2'($urandom);
			qm = 1'($urandom);
			d = {$urandom, $urandom};
			if ($urandom_range(1))
			begin
				pacc(1, s, qm, q, d);
				if (qm)
					acc[s][{q, 4'h0} +: 16] = d[15:0];
				else
					acc[s] = d;
			end
			else
			begin
				pacc(0, s, qm, q, 0);
				chk(prog_rdata, qm ? quad(acc[s], q) : acc[s]);
			end
		end
		// program port refused on slots 6 and 7; internal port reaches slot 6
		for (int i = 6; i < 8; i++)
		begin
			pacc(1, 3'(i), 0, 0, '1);
			chk(prog_slot_err, 1);
			pacc(0, 3'(i), 0, 0, 0);
			chk(prog_rdata, 0);
		end
		iacc(0, 6, 0, 0, 0);
		chk(int_rdata, 0);
		iacc(1, 6, 0, 0, d);
		iacc(0, 6, 1, 2, 0);
		chk(int_rdata, quad(d, 2));
		iacc(1, 6, 1, 0, ~d);
		iacc(0, 6, 0, 0, 0);
		chk(int_rdata, {d[63:16], ~d[15:0]});
		pacc(0, 1, 0, 0, 0);
		chk(prog_slot_err, 0);
		// exception capture, then status save into slot seven
		{exc_code, exc_addr, stat_word, stat_addr, stat_code} = 80'({$urandom, $urandom, $urandom});
		go(EXC);
		chk(exception_cause_code, exc_code);
		chk(exception_instruction_address, exc_addr);
		go(STAT);
		go(9'h0);
		chk(floating_status_word, stat_word);
		chk(exception_cause_code, stat_code);
		iacc(0, 7, 1, 2, 0);
		chk(int_rdata, stat_addr);
		iacc(0, 7, 1, 1, 0);
		chk(int_rdata, exc_addr);
		// load, store and exponent arithmetic over every operand kind
		for (int i = 0; i < 48; i++)
		begin
			k = operand_kind_t'(i % 4);
			d = (i < 4) ? 64'h8000_0000_0000_0000 : {$urandom, $urandom};
			if (k >= kind_single && d[62:55] == 8'h0)
				d[55] = 1'b1;
			word = d;
			ld_kind = k;
			ld_from_acc = 0;
			go(LD);
			if (k < kind_single)
			begin
				v = (k == kind_int16) ? {{16{word[63]}}, word[63:48]} : word[63:32];
				chk(op_sign, v[31]);
				chk(op_magnitude, v[31] ? 32'(-v) : v);
				chk(op_fraction, 0);
			end
			else
			begin
				chk(op_sign, word[63]);
				chk(op_exponent, {2'h0, word[62:55]});
				chk(op_fraction, k == kind_double ? {2'h1, word[54:0], 3'h0} : {2'h1, word[54:32], 35'h0});
			end
			st_kind = k;
			st_to_acc = 0;
			go(ST);
			chk(st_done, 1);
			chk(mem_wdata, mform(k, word));
			exp_op = exp_op_t'($urandom_range(1));
			exp_operand = 8'($urandom);
			t = (k >= kind_single) ? int'(word[62:55]) : 0;
			t = (exp_op == exp_mul) ? t + exp_operand - 128 : t - exp_operand + 128;
			go(EXP);
			chk(op_exponent, {t > 255, t < 0, 8'(t)});
			chk(stored, mform(k, word));
		end
		// store to slot six refused, load from slot seven refused
		prog_slot = 6;
		st_to_acc = 1;
		go(ST);
		chk(st_refused, 1);
		chk(prog_slot_err, 1);
		prog_slot = 7;
		ld_from_acc = 1;
		d = 64'(op_fraction);
		go(LD);
		chk(prog_slot_err, 1);
		chk(op_fraction, d);
		prog_slot = 2;
		go(ST);
		chk(st_done, 1);
		pacc(0, 2, 0, 0, 0);
		chk(prog_rdata, {word[63], 8'(t), word[54:0]});
		go(9'h0);
		end_sim();
	end
endmodule
